/* dv/sdram_four_bank_command_interface_test.sv */
// Purpose: drives the controller registers and judges the device through the link
// Assumes: refresh interval shortened to 20 cycles for run time
// Notes: device row bits above 1 alias, so rows are chosen freely
`timescale 1ns/1ps
`include "sdram_cmd_map.svh"

module sdram_four_bank_command_interface_test;
  import sdram_pkg::*;
  logic core_clk_i;
  logic resetn_i;
  logic [3:0] reg_addr_i;
  logic [31:0] reg_wdata_i;
  logic reg_wr_i;
  logic reg_rd_i;
  logic [31:0] reg_rdata_o;
  logic [3:0] bank_open_o;
  logic self_refresh_o;
  logic power_down_o;
  logic [15:0] refresh_count_o;
  logic [31:0] rv;
  int fail_count = 0;
  int cmp_count = 0;
  int cycles = 0;

  sdram_if bus ();
  sdram_device sdram_device_inst (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .pins(bus),
    .bank_open_o(bank_open_o), .self_refresh_o(self_refresh_o),
    .power_down_o(power_down_o), .refresh_count_o(refresh_count_o));
  sdram_ctl #(.REF_INTERVAL(20)) sdram_ctl_inst (.core_clk_i(core_clk_i),
    .resetn_i(resetn_i), .pins(bus), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o));
  sdram_link_props sdram_link_props_inst (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
    .cke(bus.cke), .cs_n(bus.cs_n), .ras_n(bus.ras_n), .cas_n(bus.cas_n), .we_n(bus.we_n),
    .addr(bus.addr), .dqm(bus.dqm), .ctl_dq_oe(bus.ctl_dq_oe), .mem_dq_oe(bus.mem_dq_oe));

  initial begin
    core_clk_i = 1'b0;
    forever #50 core_clk_i = ~core_clk_i;
  end

  task automatic end_of_test();
    if (fail_count == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      $display("BAD %0t timeout", $time);
      end_of_test();
    end
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask

  // waits end just past the edge so outputs have settled
  task automatic wt(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask

  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    #1;
    d = reg_rdata_o;
  endtask

  task automatic cnt(output logic [7:0] c);
    reg_rd(`REG_RDATA, rv);
    c = rv[15:8];
  endtask

  // a second command write while one is pending would be dropped, so poll first
  task automatic issue(input pin_cmd_t c, input bank_t b, input addr_t a);
    logic [3:0] code;
    logic [31:0] st;
    int n;
    code = c;
    reg_wr(`REG_CMD, {14'h0, a, b, code[2:0]});
    n = 0;
    st = 32'h1;
    while (st[0] !== 1'b0 && n < 200) begin
      reg_rd(`REG_STATUS, st);
      n++;
    end
    chk(32'(n < 200), 32'h1, "command never issued");
    wt(2);
  endtask

  task automatic t_regs();
    reg_rd(`REG_CTRL, rv);
    chk(rv[1:0], 32'h3, "ctrl reset value");
    reg_rd(4'hf, rv);
    chk(rv, 32'h0, "unmapped read");
    reg_wr(`REG_CTRL, 32'h1);
  endtask

  task automatic t_banks();
    logic [3:0] open;
    bank_t b;
    open = 4'h0;
    issue(PIN_MODE_LOAD, 2'b00, 13'h0000);
    for (int v = 0; v < 4; v++) begin
      b = bank_t'(v);
      issue(PIN_ACTIVATE, b, 13'h1fff);
      open = open | (4'h1 << {b[0], b[1]});
      chk(bank_open_o, open, "bank select");
      reg_wr(`REG_WDATA, 32'h30 + v);
      issue(PIN_WRITE, b, 13'h03ff);
      issue(PIN_READ, b, 13'h03ff);
      wt(8);
      reg_rd(`REG_RDATA, rv);
      chk(rv[7:0], 32'h30 + v, "bank data");
    end
    issue(PIN_PRECHARGE, 2'b01, 13'h0400);
    chk(bank_open_o, 4'h0, "precharge all");
  endtask

  task automatic t_bursts();
    logic [12:0] modes [5] = '{13'h000, 13'h001, 13'h002, 13'h003, 13'h00b};
    int words [5] = '{1, 2, 4, 8, 8};
    logic [7:0] c0;
    for (int i = 0; i < 5; i++) begin
      issue(PIN_MODE_LOAD, 2'b00, modes[i]);
      issue(PIN_ACTIVATE, 2'b00, 13'h0000);
      cnt(c0);
      issue(PIN_READ, 2'b00, (i == 4) ? 13'h0400 : 13'h0000);
      wt(12);
      if (i == 4) begin
        chk(bank_open_o, 4'h0, "auto precharge closes bank");
      end
      reg_rd(`REG_RDATA, rv);
      chk(8'(rv[15:8] - c0), words[i], "burst words");
      issue(PIN_PRECHARGE, 2'b00, 13'h0400);
    end
  endtask

  task automatic t_page_stop();
    logic [7:0] c0;
    logic [7:0] c1;
    logic [7:0] c2;
    issue(PIN_MODE_LOAD, 2'b00, 13'h0007);
    issue(PIN_ACTIVATE, 2'b00, 13'h0000);
    cnt(c0);
    issue(PIN_READ, 2'b00, 13'h0000);
    issue(PIN_STOP, 2'b00, 13'h0000);
    wt(6);
    cnt(c1);
    wt(8);
    cnt(c2);
    chk(32'(8'(c1 - c0) > 2), 32'h1, "page words");
    chk(c2, c1, "page stopped");
    issue(PIN_PRECHARGE, 2'b00, 13'h0400);
  endtask

  task automatic t_mask();
    for (int i = 0; i < 2; i++) begin
      issue(PIN_MODE_LOAD, 2'b00, 13'h0000);
      issue(PIN_ACTIVATE, 2'b11, 13'h0000);
      reg_wr(`REG_WDATA, 32'h5a);
      issue(PIN_WRITE, 2'b11, 13'h0007);
      issue(PIN_PRECHARGE, 2'b00, 13'h0400);
      issue(PIN_MODE_LOAD, 2'b00, (i == 1) ? 13'h0202 : 13'h0002);
      issue(PIN_ACTIVATE, 2'b11, 13'h0000);
      reg_wr(`REG_WDATA, 32'h11);
      issue(PIN_WRITE, 2'b11, 13'h0004);
      issue(PIN_READ, 2'b11, 13'h0004);
      wt(10);
      reg_rd(`REG_RDATA, rv);
      chk(rv[7:0], 32'h5a, "later burst word kept");
      issue(PIN_PRECHARGE, 2'b00, 13'h0400);
    end
  endtask

  task automatic t_cke();
    reg_wr(`REG_CTRL, 32'h0);
    wt(4);
    chk(power_down_o, 1'b1, "clock enable low");
    chk(self_refresh_o, 1'b0, "power down is not self refresh");
    reg_wr(`REG_CMD, {14'h0, 13'h0000, 2'b00, 3'h3});
    wt(10);
    reg_rd(`REG_STATUS, rv);
    chk(rv[1:0], 32'h1, "command held");
    chk(bank_open_o, 4'h0, "no activate while frozen");
    reg_wr(`REG_CTRL, 32'h1);
    wt(8);
    chk(power_down_o, 1'b0, "clock enable back");
    chk(bank_open_o, 4'h1, "activate after wake");
    issue(PIN_PRECHARGE, 2'b00, 13'h0400);
  endtask

  task automatic t_refresh();
    logic [15:0] r0;
    issue(PIN_ACTIVATE, 2'b10, 13'h0000);
    r0 = refresh_count_o;
    reg_wr(`REG_CTRL, 32'h3);
    wt(90);
    reg_wr(`REG_CTRL, 32'h1);
    wt(14);
    chk(32'(16'(refresh_count_o - r0) >= 2), 32'h1, "refresh count");
    chk(bank_open_o, 4'h0, "refresh closes rows");
  endtask

  initial begin
    resetn_i = 1'b0;
    reg_addr_i = 4'h0;
    reg_wdata_i = 32'h0;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    repeat (6) @(posedge core_clk_i);
    resetn_i <= 1'b1;
    t_regs();
    t_banks();
    t_bursts();
    t_page_stop();
    t_mask();
    t_cke();
    t_refresh();
    end_of_test();
  end
endmodule

/* dv/sdram_link_props.sv */
// Purpose: link timing properties between the controller end and the device end
// Assumes: one clock; both ends register their link outputs on its rising edge
// Notes: reads are assumed aimed at open banks, the bench keeps to that
`timescale 1ns/1ps
`include "sdram_cmd_map.svh"

module sdram_link_props (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic resetn_i,
  // command strobes
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire sdram_pkg::addr_t addr,
  // data side
  input wire logic dqm,
  input wire logic ctl_dq_oe,
  input wire logic mem_dq_oe
);
  import sdram_pkg::*;
  logic [3:0] cmd;
  logic pre_all;
  assign cmd = {cs_n, ras_n, cas_n, we_n};
  assign pre_all = (cmd == PIN_PRECHARGE) && addr[`AP_BIT];
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!resetn_i);
  // a command only counts when clock enable was also high one edge earlier
  sequence s_taken(logic [3:0] code);
    cmd == code && cke && $past(cke);
  endsequence
  a_read_first_word: assert property (
    s_taken(PIN_READ) ##1 (!dqm && cke) ##1 cke |-> ##2 mem_dq_oe)
    else $error("first read word not driven on time");
  a_mask_read_hiz: assert property (
    dqm && cke ##1 cke[*2] |-> ##1 !mem_dq_oe)
    else $error("masked read word still driven");
  a_act_col_gap: assert property (
    cmd == PIN_ACTIVATE |=> (cmd != PIN_READ && cmd != PIN_WRITE)[*2])
    else $error("column command too soon after activate");
  a_pre_act_gap: assert property (
    cmd == PIN_PRECHARGE |=> (cmd != PIN_ACTIVATE)[*2])
    else $error("activate too soon after precharge");
  a_act_pre_gap: assert property (
    cmd == PIN_ACTIVATE |=> (cmd != PIN_PRECHARGE)[*5])
    else $error("precharge too soon after activate");
  a_mode_load_gap: assert property (
    cmd == PIN_MODE_LOAD |=> (cs_n || cmd == PIN_NOP))
    else $error("command right after mode load");
  a_write_pre_gap: assert property (
    cmd == PIN_WRITE |=> cmd != PIN_PRECHARGE)
    else $error("precharge too soon after write data");
  a_write_one_word: assert property (
    cmd == PIN_WRITE |-> ctl_dq_oe && !dqm ##1 dqm)
    else $error("write word not driven or later words unmasked");
  a_refresh_after_pre: assert property (
    cmd == PIN_REFRESH |-> $past(pre_all, 3))
    else $error("refresh without precharge of all banks");
  a_cke_before_cmd: assert property (
    !cs_n && cmd != PIN_NOP |-> cke && $past(cke))
    else $error("command without clock enable high before it");
  a_stop_two_words: assert property (
    s_taken(PIN_STOP) ##0 mem_dq_oe ##1 cke[*2] |-> mem_dq_oe ##1 mem_dq_oe)
    else $error("read words missing after burst stop");
  a_stop_ends_read: assert property (
    s_taken(PIN_STOP) ##1 (cmd != PIN_READ && cke)[*3] |-> ##1 !mem_dq_oe)
    else $error("read burst runs on after stop");
endmodule

/* hw/sdram_ctl.sv */
// Purpose: memory controller end: register-driven commands with spacing and refresh
// Assumes: one command held at a time; device on the same clock
// Notes: writes are one word per command; later burst words are masked
`timescale 1ns/1ps
`include "sdram_cmd_map.svh"

module sdram_ctl #(
  parameter int REF_INTERVAL = `REF_INTERVAL_CYC
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic resetn_i,
  // memory pins
  sdram_if.ctl pins,
  // register port
  input wire logic [3:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o
);
  import sdram_pkg::*;

  typedef struct packed {
    ctl_state_t st;
    pin_cmd_t pin;
    bank_t ba;
    addr_t addr;
    logic dqm;
    data_t dq;
    logic dq_oe;
    logic cke;
    logic cke_q;
    logic cfg_cke;
    logic cfg_aref;
    logic pend;
    logic [2:0] p_op;
    bank_t p_ba;
    addr_t p_addr;
    data_t wdata;
    logic [4:0] wait_cnt;
    logic [3:0] act_age;
    bank_t act_bank;
    logic [2:0] bl;
    logic wsingle;
    logic [15:0] ref_timer;
    logic ref_due;
    data_t rd_data;
    logic [7:0] rd_count;
    logic [31:0] rdata;
  } ctl_reg_t;

  ctl_reg_t s_r;
  ctl_reg_t s_nxt;
  pin_cmd_t op;
  logic issue_ok;
  logic op_ok;
  logic [4:0] words;

  always_comb begin
    case (s_r.bl)
      3'h1: words = 5'd2;
      3'h2: words = 5'd4;
      3'h3: words = 5'd8;
      default: words = 5'd1;
    endcase
  end

  always_comb begin
    s_nxt = s_r;
    s_nxt.pin = PIN_NOP;
    s_nxt.dq_oe = 1'b0;
    s_nxt.rdata = '0;
    // the word after a write cycle and onward is masked
    s_nxt.dqm = s_r.dqm | s_r.dq_oe;
    s_nxt.cke = s_r.cfg_cke;
    s_nxt.cke_q = s_r.cke;
    op = pin_cmd_t'({1'b0, s_r.p_op});
    if (s_r.wait_cnt != 5'd0) begin
      s_nxt.wait_cnt = s_r.wait_cnt - 5'd1;
    end
    if (s_r.act_age != 4'hf) begin
      s_nxt.act_age = s_r.act_age + 4'h1;
    end
    // clock enable stays high a clock before and through the command
    issue_ok = s_r.cfg_cke && s_r.cke && s_r.cke_q && (s_r.wait_cnt == 5'd0); // R06
    case (op)
      PIN_PRECHARGE: op_ok = (s_r.act_age >= 4'(`T_RAS)); // R22
      PIN_ACTIVATE: op_ok = (s_r.act_age >= ((s_r.p_ba == s_r.act_bank) ? // R22
        4'(`T_RC) : 4'(`T_RRD)));
      default: op_ok = 1'b1;
    endcase
    case (s_r.st)
      CTL_IDLE: begin
        if (issue_ok && s_r.ref_due && (s_r.act_age >= 4'(`T_RAS))) begin
          // close every bank before refreshing
          s_nxt.pin = PIN_PRECHARGE; // R12
          s_nxt.addr = 13'h0400;
          s_nxt.wait_cnt = 5'(`T_RP - 1);
          s_nxt.st = CTL_REFRESH;
        end else if (issue_ok && s_r.pend && op_ok) begin
          s_nxt.pin = op;
          s_nxt.ba = s_r.p_ba;
          s_nxt.addr = s_r.p_addr;
          s_nxt.pend = 1'b0;
          case (op)
            PIN_MODE_LOAD: begin
              s_nxt.bl = s_r.p_addr[`MODE_BL_LSB +: 3];
              s_nxt.wsingle = s_r.p_addr[`MODE_WSINGLE_BIT];
              s_nxt.wait_cnt = 5'(`T_MRD - 1); // R11
            end
            PIN_ACTIVATE: begin
              s_nxt.act_age = 4'h1;
              s_nxt.act_bank = s_r.p_ba;
              s_nxt.wait_cnt = 5'(`T_RCD - 1); // R22
            end
            PIN_READ: begin
              s_nxt.dqm = 1'b0;
              // an auto-precharge burst must end and its bank settle first
              s_nxt.wait_cnt = s_r.p_addr[`AP_BIT] ? (words + 5'(`T_RP - 1)) : // R14 R15
                5'(`T_CCD - 1);
            end
            PIN_WRITE: begin
              s_nxt.dqm = 1'b0;
              s_nxt.dq = s_r.wdata;
              s_nxt.dq_oe = 1'b1;
              s_nxt.wait_cnt = s_r.p_addr[`AP_BIT] ? // R14 R15
                ((s_r.wsingle ? 5'd1 : words) + 5'(`T_RP - 1)) : 5'(`T_RDL - 1); // R18 R19
            end
            PIN_PRECHARGE: s_nxt.wait_cnt = 5'(`T_RP - 1); // R22
            PIN_REFRESH: s_nxt.wait_cnt = 5'(`T_RC - 1);
            PIN_STOP: s_nxt.wait_cnt = 5'(`T_BDL - 1); // R16
            default: s_nxt.wait_cnt = 5'd0;
          endcase
        end
      end
      CTL_REFRESH: begin
        if (issue_ok) begin
          s_nxt.pin = PIN_REFRESH; // R12
          s_nxt.ref_due = 1'b0;
          s_nxt.wait_cnt = 5'(`T_RC - 1);
          s_nxt.st = CTL_IDLE;
        end
      end
      default: s_nxt.st = CTL_IDLE;
    endcase
    // a timer expiry in the clearing cycle still leaves the request set
    if (s_r.ref_timer == 16'h0000) begin // R04
      s_nxt.ref_timer = 16'(REF_INTERVAL - 1);
      s_nxt.ref_due = s_r.ref_due | s_r.cfg_aref;
    end else begin
      s_nxt.ref_timer = s_r.ref_timer - 16'h0001;
    end
    // read words land three edges after the read command
    if (pins.mem_dq_oe) begin // R02
      s_nxt.rd_data = pins.dq;
      s_nxt.rd_count = s_r.rd_count + 8'h01;
    end
    if (reg_wr_i) begin
      case (reg_addr_i)
        `REG_CMD: begin
          if (!s_r.pend) begin
            s_nxt.pend = 1'b1;
            s_nxt.p_op = reg_wdata_i[`CMD_OP_LSB +: 3];
            s_nxt.p_ba = reg_wdata_i[`CMD_BANK_LSB +: 2];
            s_nxt.p_addr = reg_wdata_i[`CMD_ADDR_LSB +: 13];
          end
        end
        `REG_WDATA: s_nxt.wdata = reg_wdata_i[7:0];
        `REG_CTRL: begin
          s_nxt.cfg_cke = reg_wdata_i[`CTRL_CKE_BIT];
          s_nxt.cfg_aref = reg_wdata_i[`CTRL_AREF_BIT];
        end
        default: begin
        end
      endcase
    end
    if (reg_rd_i) begin
      case (reg_addr_i)
        `REG_CMD: s_nxt.rdata = {14'h0, s_r.p_addr, s_r.p_ba, s_r.p_op};
        `REG_WDATA: s_nxt.rdata = {24'h0, s_r.wdata};
        `REG_CTRL: s_nxt.rdata = {30'h0, s_r.cfg_aref, s_r.cfg_cke};
        `REG_STATUS: s_nxt.rdata = {28'h0, s_r.ref_due, s_r.st == CTL_REFRESH, s_r.cke, s_r.pend};
        `REG_RDATA: s_nxt.rdata = {16'h0, s_r.rd_count, s_r.rd_data};
        default: s_nxt.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_r <= '0;
      s_r.st <= CTL_IDLE;
      s_r.pin <= PIN_NOP;
      s_r.dqm <= 1'b1;
      s_r.cfg_cke <= `CTRL_CKE_RST;
      s_r.cfg_aref <= `CTRL_AREF_RST;
      s_r.act_age <= 4'hf;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign pins.cke = s_r.cke;
  assign pins.cs_n = s_r.pin[3];
  assign pins.ras_n = s_r.pin[2];
  assign pins.cas_n = s_r.pin[1];
  assign pins.we_n = s_r.pin[0];
  assign pins.bank_select_bits = s_r.ba;
  assign pins.addr = s_r.addr;
  assign pins.dqm = s_r.dqm;
  assign pins.ctl_dq = s_r.dq;
  assign pins.ctl_dq_oe = s_r.dq_oe;
  assign reg_rdata_o = s_r.rdata;
endmodule

/* hw/sdram_device.sv */
// Purpose: four-bank byte-wide synchronous DRAM, command and data behaviour at its pins
// Assumes: controller keeps the spacings it is bound to; same clock on both ends
// Notes: storage keeps only ROW_KEEP low row bits per bank to stay small
// Behaviour
// R01: all inputs sampled on rising clock edge only
// R02: read latency three; bursts 1,2,4,8,page
// R03: burst reads with single-word writes option
// R04: controller refreshes 8K rows each 64 ms
// R05: chip select high blocks every command
// R06: clock enable low freezes from next clock
// R07: 13-bit row, 10-bit column, shared pins
// R08: bank bits choose banks A, B, C, D
// R09: precharge with ap bit closes all banks
// R10: command decode from four strobe pins
// R11: mode load only idle, then wait 2
// R12: refresh only with all banks precharged
// R13: auto refresh precharges rows by itself
// R14: no column command during auto-precharge burst
// R15: same-bank activate only after burst end
// R16: burst stop ends burst at any length
// R17: mask: write latency 0, read latency 2
// R18: two clocks from write data to precharge
// R19: one clock write data to column/stop
// R20: new column address accepted every clock
// R21: two more read words after interruption
// R22: controller keeps activate/precharge spacings
// R23: first read word three edges after command
`timescale 1ns/1ps
`include "sdram_cmd_map.svh"

module sdram_device #(
  parameter int ROW_KEEP = 2
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic resetn_i,
  // memory pins
  sdram_if.mem pins,
  // status
  output logic [3:0] bank_open_o,
  output logic self_refresh_o,
  output logic power_down_o,
  output logic [15:0] refresh_count_o
);
  import sdram_pkg::*;

  localparam int MEM_AW = 2 + ROW_KEEP + `COL_W;

  typedef struct packed {
    logic cke_q;
    addr_t mode;
    logic [3:0] open;
    logic [3:0][`ROW_W-1:0] row;
    logic burst;
    logic bwr;
    logic bap;
    bank_t bbank;
    logic [`COL_W-1:0] bcol;
    logic [`COL_W-1:0] bcnt;
    logic selfref;
    logic [1:0] rvld;
    logic [1:0][7:0] rpipe;
    logic [1:0] dqm_p;
    data_t dq;
    logic dq_oe;
    logic [15:0] ref_cnt;
  } dev_state_t;

  dev_state_t s_r;
  dev_state_t s_nxt;
  data_t mem [0:(1<<MEM_AW)-1];

  pin_cmd_t cmd;
  bank_t cmd_bank;
  logic [`COL_W-1:0] len_mask;
  logic [`COL_W-1:0] col_cur;
  logic full_page;
  logic burst_last;
  logic wr_en;
  logic [MEM_AW-1:0] wr_idx;
  logic [MEM_AW-1:0] rd_idx;
  data_t wr_dat;

  // column of word n inside a burst; the wrap stays within the burst-aligned block
  function automatic logic [`COL_W-1:0] burst_col(
    input logic [`COL_W-1:0] base,
    input logic [`COL_W-1:0] n,
    input logic [`COL_W-1:0] mask,
    input logic ilv
  );
    logic [`COL_W-1:0] off;
    off = ilv ? (base ^ n) : (base + n);
    return (base & ~mask) | (off & mask);
  endfunction

  always_comb begin
    case (s_r.mode[`MODE_BL_LSB +: 3]) // R02
      3'h0: len_mask = 10'h000;
      3'h1: len_mask = 10'h001;
      3'h2: len_mask = 10'h003;
      3'h3: len_mask = 10'h007;
      `BL_FULL: len_mask = 10'h3ff;
      default: len_mask = 10'h000;
    endcase
  end

  assign full_page = (s_r.mode[`MODE_BL_LSB +: 3] == `BL_FULL);
  assign col_cur = burst_col(s_r.bcol, s_r.bcnt, len_mask, s_r.mode[`MODE_TYPE_BIT]);
  assign burst_last = !full_page && (s_r.bcnt == len_mask);
  // bank A..D = index 0..3; bit 1 alone gives B, bit 0 alone gives C
  assign cmd_bank = {pins.bank_select_bits[0], pins.bank_select_bits[1]}; // R08
  assign rd_idx = {s_r.bbank, s_r.row[s_r.bbank][ROW_KEEP-1:0], col_cur};

  always_comb begin
    s_nxt = s_r;
    // chip select high turns every command into a no-operation
    cmd = pins.cs_n ? PIN_NOP : pin_cmd_t'({1'b0, pins.ras_n, pins.cas_n, pins.we_n}); // R05 R10
    wr_en = 1'b0;
    wr_idx = {s_r.bbank, s_r.row[s_r.bbank][ROW_KEEP-1:0], col_cur};
    wr_dat = pins.dq;
    s_nxt.cke_q = pins.cke; // R06
    if (s_r.selfref) begin
      // only clock enable is watched until self refresh ends
      if (pins.cke) begin
        s_nxt.selfref = 1'b0;
      end
    end else if (s_r.cke_q) begin
      // read path: address stage, two pipe stages, output register
      s_nxt.dqm_p = {s_r.dqm_p[0], pins.dqm}; // R17
      s_nxt.rvld = {s_r.rvld[0], s_r.burst && !s_r.bwr};
      s_nxt.rpipe = {s_r.rpipe[0], mem[rd_idx]}; // R23
      s_nxt.dq = s_r.rpipe[1];
      s_nxt.dq_oe = s_r.rvld[1] && !s_r.dqm_p[1]; // R17
      if (s_r.burst) begin
        if (s_r.bwr && !pins.dqm) begin
          wr_en = 1'b1; // R17
        end
        s_nxt.bcnt = s_r.bcnt + 10'h001;
        if (burst_last) begin
          s_nxt.burst = 1'b0;
          if (s_r.bap) begin
            s_nxt.open[s_r.bbank] = 1'b0;
          end
        end
      end
      case (cmd)
        PIN_MODE_LOAD: begin
          s_nxt.mode = pins.addr;
        end
        PIN_ACTIVATE: begin
          s_nxt.open[cmd_bank] = 1'b1;
          s_nxt.row[cmd_bank] = pins.addr; // R07
        end
        PIN_READ: begin
          // a new column command replaces any burst in flight
          if (s_r.open[cmd_bank]) begin // R20
            s_nxt.burst = 1'b1;
            s_nxt.bwr = 1'b0;
            s_nxt.bap = pins.addr[`AP_BIT];
            s_nxt.bbank = cmd_bank;
            s_nxt.bcol = pins.addr[`COL_W-1:0]; // R07
            s_nxt.bcnt = '0;
          end
        end
        PIN_WRITE: begin
          if (s_r.open[cmd_bank]) begin // R20
            // first word is taken with the command itself
            wr_en = !pins.dqm; // R17
            wr_idx = {cmd_bank, s_r.row[cmd_bank][ROW_KEEP-1:0], pins.addr[`COL_W-1:0]};
            s_nxt.bwr = 1'b1;
            s_nxt.bap = pins.addr[`AP_BIT];
            s_nxt.bbank = cmd_bank;
            s_nxt.bcol = pins.addr[`COL_W-1:0];
            s_nxt.bcnt = 10'h001;
            if (s_r.mode[`MODE_WSINGLE_BIT] || (len_mask == 10'h000)) begin // R03
              s_nxt.burst = 1'b0;
              if (pins.addr[`AP_BIT]) begin
                s_nxt.open[cmd_bank] = 1'b0;
              end
            end else begin
              s_nxt.burst = 1'b1;
            end
          end
        end
        PIN_PRECHARGE: begin
          if (pins.addr[`AP_BIT]) begin
            s_nxt.open = 4'h0; // R09
          end else begin
            s_nxt.open[cmd_bank] = 1'b0;
          end
          // words already in the read pipe still come out
          if (pins.addr[`AP_BIT] || (cmd_bank == s_r.bbank)) begin // R21
            s_nxt.burst = 1'b0;
          end
        end
        PIN_STOP: begin
          s_nxt.burst = 1'b0; // R16 R21
        end
        PIN_REFRESH: begin
          // the row counter advances; rows are precharged internally
          s_nxt.ref_cnt = s_r.ref_cnt + 16'h0001;
          s_nxt.open = 4'h0; // R13
          if (!pins.cke) begin
            s_nxt.selfref = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin // R01
    if (!resetn_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // storage has no reset: contents are undefined until written
  always_ff @(posedge core_clk_i) begin
    if (wr_en) begin
      mem[wr_idx] <= wr_dat;
    end
  end

  assign pins.mem_dq = s_r.dq;
  assign pins.mem_dq_oe = s_r.dq_oe;
  assign bank_open_o = s_r.open;
  assign self_refresh_o = s_r.selfref;
  assign power_down_o = !s_r.cke_q;
  assign refresh_count_o = s_r.ref_cnt;
endmodule

/* include/sdram_cmd_map.svh */
// Purpose: numeric map shared by both ends of the synchronous DRAM link
// Assumes: 10 MHz core clock (100 ns period)
// Notes: mode-word field positions and controller register offsets are local choices
`ifndef SDRAM_CMD_MAP_SVH
`define SDRAM_CMD_MAP_SVH

// address pin widths
`define ROW_W 13
`define COL_W 10
`define AP_BIT 10

// mode word fields, loaded from the address pins
`define MODE_BL_LSB 0
`define MODE_TYPE_BIT 3
`define MODE_WSINGLE_BIT 9
`define BL_FULL 3'h7
`define READ_LATENCY 3

// least command spacings in clocks
`define T_MRD 2
`define T_RCD 3
`define T_RP 3
`define T_RRD 2
`define T_RAS 6
`define T_RC 9
`define T_RDL 2
`define T_CCD 1
`define T_BDL 1

// refresh: 8K rows every 64 ms, interval rounded down to whole cycles
`define REF_PERIOD_NS 64000000
`define REF_ROWS 8192
`define CLK_PERIOD_NS 100
`define REF_INTERVAL_CYC (`REF_PERIOD_NS / `REF_ROWS / `CLK_PERIOD_NS)

// controller register offsets
`define REG_CMD 4'h0
`define REG_WDATA 4'h1
`define REG_CTRL 4'h2
`define REG_STATUS 4'h3
`define REG_RDATA 4'h4

// controller register fields
`define CMD_OP_LSB 0
`define CMD_BANK_LSB 3
`define CMD_ADDR_LSB 5
`define CTRL_CKE_BIT 0
`define CTRL_AREF_BIT 1

// reset values
`define CTRL_CKE_RST 1'b1
`define CTRL_AREF_RST 1'b1

`endif

/* include/sdram_if.sv */
// Purpose: pin bundle between memory controller and DRAM device
// Assumes: both ends on core_clk_i
// Notes: dq is resolved here from the two drivers; device wins a collision
`timescale 1ns/1ps
interface sdram_if;
  logic cke;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  sdram_pkg::bank_t bank_select_bits;
  sdram_pkg::addr_t addr;
  logic dqm;
  sdram_pkg::data_t ctl_dq;
  logic ctl_dq_oe;
  sdram_pkg::data_t mem_dq;
  logic mem_dq_oe;
  sdram_pkg::data_t dq;

  assign dq = mem_dq_oe ? mem_dq : ctl_dq;

  modport ctl (
    output cke, cs_n, ras_n, cas_n, we_n, bank_select_bits, addr, dqm, ctl_dq, ctl_dq_oe,
    input mem_dq_oe, dq
  );
  modport mem (
    input cke, cs_n, ras_n, cas_n, we_n, bank_select_bits, addr, dqm, dq,
    output mem_dq, mem_dq_oe
  );
endinterface

/* include/sdram_pkg.sv */
// Purpose: types shared by the memory end and the controller end
// Assumes: nothing
// Notes: command code is {cs_n, ras_n, cas_n, we_n}
package sdram_pkg;
  typedef enum logic [3:0] {
    PIN_MODE_LOAD = 4'h0,
    PIN_REFRESH = 4'h1,
    PIN_PRECHARGE = 4'h2,
    PIN_ACTIVATE = 4'h3,
    PIN_WRITE = 4'h4,
    PIN_READ = 4'h5,
    PIN_STOP = 4'h6,
    PIN_NOP = 4'h7
  } pin_cmd_t;
  typedef enum logic [1:0] {
    CTL_IDLE = 2'b01,
    CTL_REFRESH = 2'b10
  } ctl_state_t;
  typedef logic [12:0] addr_t;
  typedef logic [1:0] bank_t;
  typedef logic [7:0] data_t;
endpackage
